/* src/strap_decode.sv */
`timescale 1ns/10ps
// ============================================================
// strap decoder: turns held strap levels into mode controls
module strap_decode (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // held settings
    input wire logic running,
    input strap_pkg::strap_t straps,
    input wire logic rmii_int,
    input wire logic gig_sel,
    // decoded modes
    output strap_pkg::cfg_t cfg
);

    strap_pkg::cfg_t cfg_q;
    strap_pkg::cfg_t cfg_d;
    logic rmii;

    always_comb begin
        rmii = strap_pkg::iftype_is(straps, strap_pkg::IF_RMII);
        cfg_d = strap_pkg::CFG_RESET;
        if (running) begin
            cfg_d.refclk_out_en = straps.refclk_enable_strap;
            cfg_d.if_mii = strap_pkg::iftype_is(straps, strap_pkg::IF_MII);
            cfg_d.if_rmii = rmii;
            cfg_d.if_rgmii = strap_pkg::iftype_is(straps, strap_pkg::IF_RGMII);
            cfg_d.if_reserved = strap_pkg::iftype_is(straps, strap_pkg::IF_RSVD);
            // role strap only means MAC versus PHY in MII
            cfg_d.mii_mac = cfg_d.if_mii & straps.uplink_role_strap;
            cfg_d.rmii_clk_out = rmii & rmii_int;
            cfg_d.rmii_ref_in = rmii & ~rmii_int;
            cfg_d.gigabit = cfg_d.if_rgmii & gig_sel;
            cfg_d.pll_ref_ext = rmii & ~rmii_int & ~straps.pll_source_strap;
            cfg_d.mdio_mode = straps.serial_out_bus_select_strap;
            cfg_d.synth_en = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= strap_pkg::CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    assign cfg = cfg_q;

endmodule : strap_decode

/* src/strap_option_sampler.sv */
// Function
// - capture straps at end of each reset
// - straps inputs with pulls during reset
// - refclk strap high enables reference output
// - MII role strap selects MAC or PHY
// - RMII role high drives 50MHz clock out
// - RMII role low takes external 50MHz
// - RMII clock source from strap or register
// - interface type 00 MII 01 RMII 11 RGMII
// - RGMII speed strap gigabit, register override
// - PLL source strap picks crystal or external, only in RMII with external 50MHz
// - serial strap low SPI, high MDIO
// - synthesizer runs from selected reference
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
module strap_option_sampler (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [strap_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // warm reset request, level
    input wire logic warm_reset_req,
    // strap pins
    input strap_pkg::strap_t strap_in,
    output strap_pkg::strap_t strap_out,
    output strap_pkg::strap_t strap_oe,
    output logic pull_en,
    // normal pin function (led and serial output logic)
    input strap_pkg::strap_t func_out,
    input strap_pkg::strap_t func_oe,
    // decoded configuration
    output strap_pkg::cfg_t cfg,
    output logic running
);

    // ============================================================
    // declarations
    strap_pkg::state_t state_q;
    strap_pkg::state_t state_d;
    strap_pkg::strap_t straps_q;
    strap_pkg::strap_t strap_out_q;
    strap_pkg::strap_t strap_oe_q;
    logic pull_en_q;
    logic running_q;
    logic capture;
    logic rmii_int_q;
    logic gig_q;
    logic [7:0] cnt_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic setup;
    logic wr_en;
    logic [9:0] idx;

    // word index of a byte address
    function automatic logic [9:0] word_index(input logic [strap_pkg::ADDR_W-1:0] a);
        word_index = a[strap_pkg::ADDR_W-1:2];
    endfunction : word_index

    function automatic logic reg_hit(input logic [9:0] i);
        reg_hit = (i == strap_pkg::IDX_STRAP) || (i == strap_pkg::IDX_SPEED)
            || (i == strap_pkg::IDX_RMII);
    endfunction : reg_hit

    // ============================================================
    // reset sequencer
    // a warm reset sends the block back to sampling; levels are taken
    // at the first edge where no reset is pending
    assign capture = (state_q == strap_pkg::ST_SAMPLE) && !warm_reset_req;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            strap_pkg::ST_SAMPLE: begin
                if (!warm_reset_req) begin
                    state_d = strap_pkg::ST_RUN;
                end
            end
            strap_pkg::ST_RUN: begin
                if (warm_reset_req) begin
                    state_d = strap_pkg::ST_SAMPLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= strap_pkg::ST_SAMPLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running_q <= 1'b0;
        end else begin
            running_q <= (state_d == strap_pkg::ST_RUN);
        end
    end

    // ============================================================
    // strap capture
    // reset loads the pull levels; the real pin levels are taken by the
    // clocked capture after release, never through the async branch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            straps_q <= strap_pkg::STRAP_DEFAULT;
        end else if (capture) begin
            straps_q <= strap_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 8'h00;
        end else if (capture) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // ============================================================
    // pin direction
    // pins stay inputs through the capture edge so the sampled level is
    // the board resistor's, not our own drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_en_q <= 1'b1;
            strap_oe_q <= 7'h00;
        end else begin
            pull_en_q <= (state_d == strap_pkg::ST_SAMPLE);
            if (state_d == strap_pkg::ST_RUN) begin
                strap_oe_q <= func_oe;
            end else begin
                strap_oe_q <= 7'h00;
            end
        end
    end

    // later pin activity reaches only these flops, never straps_q
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_out_q <= 7'h00;
        end else if (state_d == strap_pkg::ST_RUN) begin
            strap_out_q <= func_out;
        end else begin
            strap_out_q <= 7'h00;
        end
    end

    // ============================================================
    // apb slave: answer in the first access cycle
    assign idx = word_index(paddr);
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready_q && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            // the strap copy is read only, so a write there is an error
            pslverr_q <= setup && (!reg_hit(idx)
                || (pwrite && idx == strap_pkg::IDX_STRAP));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_q <= 32'h0000_0000;
            if (idx == strap_pkg::IDX_STRAP) begin
                prdata_q[6:0] <= straps_q;
                prdata_q[strap_pkg::RUN_BIT] <= running_q;
                prdata_q[strap_pkg::CNT_LSB +: 8] <= cnt_q;
            end else if (idx == strap_pkg::IDX_SPEED) begin
                prdata_q[strap_pkg::GIG_BIT] <= gig_q;
            end else if (idx == strap_pkg::IDX_RMII) begin
                prdata_q[strap_pkg::RMII_INT_BIT] <= rmii_int_q;
            end
        end else if (!psel) begin
            prdata_q <= 32'h0000_0000;
        end
    end

    // ============================================================
    // software overrides
    // a capture in the same cycle as a write wins: a reset outranks software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rmii_int_q <= strap_pkg::STRAP_DEFAULT.uplink_role_strap;
        end else if (capture) begin
            rmii_int_q <= strap_in.uplink_role_strap;
        end else if (wr_en && idx == strap_pkg::IDX_RMII) begin
            rmii_int_q <= pwdata[strap_pkg::RMII_INT_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gig_q <= strap_pkg::STRAP_DEFAULT.uplink_gigabit_strap;
        end else if (capture) begin
            gig_q <= strap_in.uplink_gigabit_strap;
        end else if (wr_en && idx == strap_pkg::IDX_SPEED) begin
            gig_q <= pwdata[strap_pkg::GIG_BIT];
        end
    end

    // ============================================================
    // mode decoder
    strap_decode u_decode (
        .pclk(pclk),
        .presetn(presetn),
        .running(running_q),
        .straps(straps_q),
        .rmii_int(rmii_int_q),
        .gig_sel(gig_q),
        .cfg(cfg)
    );

    // ============================================================
    // outputs
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign strap_out = strap_out_q;
    assign strap_oe = strap_oe_q;
    assign pull_en = pull_en_q;
    assign running = running_q;

    // ============================================================
    // checks
    chk_capture_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        (capture && presetn) |=> (straps_q == $past(strap_in)) && running_q)
        else $error("strap levels not captured at reset end");

    chk_warm_resample: assert property (
        @(posedge pclk) disable iff (!presetn)
        (running_q && warm_reset_req) |=> (state_q == strap_pkg::ST_SAMPLE)
            && pull_en_q)
        else $error("warm reset did not return to sampling");

    chk_pins_input: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_q == strap_pkg::ST_SAMPLE) |-> pull_en_q && (strap_oe_q == 7'h00))
        else $error("strap pin driven during reset");

    chk_pins_output: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 (running_q && $past(running_q)) |-> !pull_en_q
            && (strap_oe_q == $past(func_oe)))
        else $error("strap pin not back to output function");

    chk_hold_stable: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_q == strap_pkg::ST_RUN) |=> $stable(straps_q) || capture)
        else $error("held strap levels changed while running");

    chk_rmii_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && !capture && idx == strap_pkg::IDX_RMII)
            |=> ##1 (cfg.rmii_clk_out == (cfg.if_rmii && $past(pwdata[7], 2))))
        else $error("rmii clock source write not applied");

    chk_speed_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && !capture && running_q && idx == strap_pkg::IDX_SPEED)
            |=> ##1 (cfg.gigabit == (cfg.if_rgmii && $past(pwdata[0], 2))))
        else $error("gigabit override write not applied");

    chk_apb_answer: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup |=> pready_q ##1 !pready_q)
        else $error("apb answer not exactly one access cycle");

    chk_refclk_enable: assert property (
        @(posedge pclk) disable iff (!presetn)
        running_q ##1 running_q |-> cfg.refclk_out_en == straps_q.refclk_enable_strap)
        else $error("reference clock enable not following strap");

    chk_iftype_decode: assert property (
        @(posedge pclk) disable iff (!presetn)
        running_q ##1 running_q |-> $onehot({cfg.if_mii, cfg.if_rmii,
            cfg.if_rgmii, cfg.if_reserved}))
        else $error("interface type decode not one-hot");

    chk_mii_role: assert property (
        @(posedge pclk) disable iff (!presetn)
        cfg.mii_mac |-> cfg.if_mii && straps_q.uplink_role_strap)
        else $error("mac role outside mii or with low strap");

    chk_rmii_clock: assert property (
        @(posedge pclk) disable iff (!presetn)
        cfg.if_rmii |-> (cfg.rmii_clk_out != cfg.rmii_ref_in))
        else $error("rmii clock mode and reference input both or neither");

    chk_pll_source: assert property (
        @(posedge pclk) disable iff (!presetn)
        cfg.pll_ref_ext |-> cfg.rmii_ref_in && !straps_q.pll_source_strap)
        else $error("external pll reference outside rmii normal mode");

    chk_bus_select: assert property (
        @(posedge pclk) disable iff (!presetn)
        running_q ##1 running_q |-> cfg.mdio_mode
            == straps_q.serial_out_bus_select_strap)
        else $error("serial bus type not following strap");

    chk_synth_run: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(running_q) |=> cfg.synth_en)
        else $error("clock synthesizer not enabled after capture");

    // sampled presetn keeps the release edge, which still resets, out of the count
    chk_capture_count: assert property (
        @(posedge pclk) disable iff (!presetn)
        (capture && presetn) |=> cnt_q == $past(cnt_q) + 8'h01)
        else $error("capture count did not advance");

    chk_read_strap: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && idx == strap_pkg::IDX_STRAP) |=> prdata_q[6:0] == $past(straps_q))
        else $error("strap copy read back wrong");

    chk_strap_refuse: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && pwrite && idx == strap_pkg::IDX_STRAP) |=> pready_q && pslverr_q)
        else $error("write to strap copy not refused");

    chk_cfg_cleared: assert property (
        @(posedge pclk) disable iff (!presetn)
        !running_q |=> (cfg == strap_pkg::CFG_RESET))
        else $error("decoded modes not cleared while sampling");

endmodule : strap_option_sampler

/* src/strap_pkg.sv */
// ============================================================
// strap sampler shared definitions
package strap_pkg;

    // ============================================================
    // register map: printed offset 0x56 is not word aligned, so all
    // offsets are indices and the byte address is four times the index
    localparam int ADDR_W = 12;
    localparam logic [9:0] IDX_STRAP = 10'h000;
    localparam logic [9:0] IDX_SPEED = 10'h001;
    localparam logic [9:0] IDX_RMII = 10'h056;
    localparam int RMII_INT_BIT = 7;
    localparam int GIG_BIT = 0;
    localparam int RUN_BIT = 8;
    localparam int CNT_LSB = 16;

    // ============================================================
    // clocks: apb clock and those named by the straps (MHz)
    localparam int PCLK_MHZ = 40;
    localparam int REFCLK_OUT_MHZ = 25;
    localparam int RMII_CLK_MHZ = 50;

    // ============================================================
    // strap pins, one bit per pin
    typedef struct packed {
        logic serial_out_bus_select_strap;
        logic pll_source_strap;
        logic uplink_gigabit_strap;
        logic [1:0] uplink_interface_type_strap;
        logic uplink_role_strap;
        logic refclk_enable_strap;
    } strap_t;

    // internal pull levels: all pulled up except the serial bus select
    localparam strap_t STRAP_DEFAULT = 7'h3F;

    localparam logic [1:0] IF_MII = 2'h0;
    localparam logic [1:0] IF_RMII = 2'h1;
    localparam logic [1:0] IF_RSVD = 2'h2;
    localparam logic [1:0] IF_RGMII = 2'h3;

    // ============================================================
    // decoded configuration
    typedef struct packed {
        logic refclk_out_en;
        logic if_mii;
        logic if_rmii;
        logic if_rgmii;
        logic if_reserved;
        logic mii_mac;
        logic rmii_clk_out;
        logic rmii_ref_in;
        logic gigabit;
        logic pll_ref_ext;
        logic mdio_mode;
        logic synth_en;
    } cfg_t;

    localparam cfg_t CFG_RESET = 12'h000;

    typedef enum logic [1:0] {
        ST_SAMPLE = 2'h1,
        ST_RUN = 2'h2
    } state_t;

    function automatic logic iftype_is(input strap_t s, input logic [1:0] code);
        iftype_is = (s.uplink_interface_type_strap == code);
    endfunction : iftype_is

endpackage : strap_pkg

/* tb/strap_board.sv */
`timescale 1ns/10ps
// ============================================================
// board side: each strap pin has a resistor to one rail
module strap_board (
    // device pin drive
    input strap_pkg::strap_t strap_out,
    input strap_pkg::strap_t strap_oe,
    // resistor rail per pin
    input strap_pkg::strap_t resistor_level,
    // level seen on the pins
    output strap_pkg::strap_t strap_in
);
    // a driven pin follows the device; an undriven one settles to its resistor
    assign strap_in = (strap_out & strap_oe) | (resistor_level & ~strap_oe);
endmodule : strap_board

/* tb/tb_top.sv */
`timescale 1ns/10ps
// ============================================================
// strap sampler bench
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic warm_reset_req = 1'b0;
    strap_pkg::strap_t strap_in, strap_out, strap_oe, board_q;
    strap_pkg::strap_t func_out = 7'h00;
    strap_pkg::strap_t func_oe = 7'h00;
    strap_pkg::cfg_t cfg;
    logic pull_en;
    logic running;
    int miscompares = 0;
    int n_compared = 0;
    logic [31:0] rd;
    logic err;
    logic [7:0] cnt_q;
    strap_pkg::strap_t cases [8] = '{7'h3F, 7'h62, 7'h00, 7'h37, 7'h15, 7'h64, 7'h2D, 7'h3B};

    initial board_q = 7'h3F;
    initial forever #12.5 pclk = ~pclk;

    strap_board board (.strap_out(strap_out), .strap_oe(strap_oe), .resistor_level(board_q),
        .strap_in(strap_in));

    strap_option_sampler DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .warm_reset_req(warm_reset_req),
        .strap_in(strap_in), .strap_out(strap_out), .strap_oe(strap_oe), .pull_en(pull_en),
        .func_out(func_out), .func_oe(func_oe), .cfg(cfg), .running(running));

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task complete_run;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    // one apb transfer; holds the request until pready is seen at a rising edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            @(posedge pclk);
        end
        check("pready wait", n, 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic strap_pkg::cfg_t exp_cfg(input strap_pkg::strap_t s, input logic ri,
        input logic g);
        strap_pkg::cfg_t c;
        logic rmii;
        rmii = (s.uplink_interface_type_strap == 2'h1);
        c = 12'h000;
        c.refclk_out_en = s.refclk_enable_strap;
        c.if_mii = (s.uplink_interface_type_strap == 2'h0);
        c.if_rmii = rmii;
        c.if_rgmii = (s.uplink_interface_type_strap == 2'h3);
        c.if_reserved = (s.uplink_interface_type_strap == 2'h2);
        c.mii_mac = c.if_mii & s.uplink_role_strap;
        c.rmii_clk_out = rmii & ri;
        c.rmii_ref_in = rmii & ~ri;
        c.gigabit = c.if_rgmii & g;
        c.pll_ref_ext = rmii & ~ri & ~s.pll_source_strap;
        c.mdio_mode = s.serial_out_bus_select_strap;
        c.synth_en = 1'b1;
        return c;
    endfunction : exp_cfg

    // ============================================================
    // warm reset with new board straps, pins must be inputs meanwhile
    task warm_capture(input strap_pkg::strap_t s);
        @(posedge pclk);
        warm_reset_req <= 1'b1;
        board_q <= s;
        repeat (3) @(negedge pclk);
        check("pull_en warm", pull_en, 1'b1);
        check("oe warm", strap_oe, 7'h00);
        check("running warm", running, 1'b0);
        @(posedge pclk);
        warm_reset_req <= 1'b0;
        repeat (3) @(negedge pclk);
        check("running", running, 1'b1);
        check("pull_en run", pull_en, 1'b0);
    endtask : warm_capture

    task test_table;
        for (int i = 0; i < 8; i++) begin
            warm_capture(cases[i]);
            if (cases[i].uplink_interface_type_strap == 2'h2) begin
                check("cfg rsvd", cfg[10:7], 4'h1);
            end else begin
                check("cfg", cfg, exp_cfg(cases[i], cases[i].uplink_role_strap,
                    cases[i].uplink_gigabit_strap));
            end
            apb(1'b0, 12'h000, 32'h0);
            check("strap reg", rd[6:0], cases[i]);
            check("capture count", rd[23:16], cnt_q + 8'h01);
            cnt_q = rd[23:16];
            apb(1'b0, 12'h004, 32'h0);
            check("speed reg", rd[0], cases[i].uplink_gigabit_strap);
            apb(1'b0, 12'h158, 32'h0);
            check("rmii reg", rd[7], cases[i].uplink_role_strap);
        end
    endtask : test_table

    // pins back in normal output use must not disturb held settings
    task test_hold;
        warm_capture(7'h37);
        @(posedge pclk);
        func_out <= 7'h48;
        func_oe <= 7'h7F;
        repeat (4) @(negedge pclk);
        check("oe run", strap_oe, 7'h7F);
        check("out run", strap_out, 7'h48);
        check("cfg held", cfg, exp_cfg(7'h37, 1'b1, 1'b1));
        apb(1'b0, 12'h000, 32'h0);
        check("strap held", rd[6:0], 7'h37);
        @(posedge pclk);
        func_oe <= 7'h00;
        cnt_q = cnt_q + 8'h01;
    endtask : test_hold

    // software overrides for rmii clock source and rgmii speed
    task test_override;
        apb(1'b1, 12'h158, 32'h00000000);
        check("rmii wr err", err, 1'b0);
        repeat (3) @(negedge pclk);
        check("cfg rmii ext", cfg, exp_cfg(7'h37, 1'b0, 1'b1));
        apb(1'b0, 12'h158, 32'h0);
        check("rmii rb", rd[7], 1'b0);
        warm_capture(7'h3F);
        apb(1'b1, 12'h004, 32'h00000000);
        repeat (3) @(negedge pclk);
        check("cfg speed", cfg, exp_cfg(7'h3F, 1'b1, 1'b0));
        apb(1'b1, 12'h004, 32'h00000001);
        repeat (3) @(negedge pclk);
        check("cfg gig", cfg.gigabit, 1'b1);
    endtask : test_override

    task test_refuse;
        apb(1'b1, 12'h000, 32'h0000007F);
        check("strap wr err", err, 1'b1);
        apb(1'b0, 12'h000, 32'h0);
        check("strap unchanged", rd[6:0], 7'h3F);
        apb(1'b0, 12'h008, 32'h0);
        check("unmapped err", err, 1'b1);
        check("unmapped data", rd, 32'h00000000);
    endtask : test_refuse

    // power-on release: default pulls captured, first capture counted
    task test_power;
        repeat (2) @(negedge pclk);
        check("pull_en rst", pull_en, 1'b1);
        check("cfg rst", cfg, 12'h000);
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(negedge pclk);
        check("cfg power", cfg, exp_cfg(7'h3F, 1'b1, 1'b1));
        apb(1'b0, 12'h000, 32'h0);
        check("capture count power", rd[23:16], 8'h01);
        cnt_q = rd[23:16];
    endtask : test_power

    // power-down reset in mid-run: new board straps captured, capture count back to one
    task test_cold;
        @(posedge pclk);
        presetn <= 1'b0;
        board_q <= 7'h62;
        repeat (2) @(negedge pclk);
        check("pull_en cold", pull_en, 1'b1);
        check("oe cold", strap_oe, 7'h00);
        check("cfg cold", cfg, 12'h000);
        check("running cold", running, 1'b0);
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(negedge pclk);
        check("cfg after cold", cfg, exp_cfg(7'h62, 1'b1, 1'b0));
        apb(1'b0, 12'h000, 32'h0);
        check("strap cold", rd[6:0], 7'h62);
        check("count cold", rd[23:16], 8'h01);
    endtask : test_cold

    initial begin
        test_power();
        test_table();
        test_hold();
        test_override();
        test_refuse();
        test_cold();
        complete_run();
    end

    initial begin
        #200us;
        miscompares++;
        complete_run();
    end
endmodule : tb_top
